// file: hw/tcpc_top.sv
// Purpose: Shared 16-bit counter with output compare and PWM channels
// Assumes: AXI4-Lite slave, single clock aclk, synchronous inputs
// Notes:   Input capture itself is not built; capture mode releases pins
//
// Added by the designer: the address map and the AXI4-Lite register port.
module tcpc_top (
	// Clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// AXI4-Lite write address and data
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [7:0]                    awaddr,
	input  wire logic                          wvalid,
	output logic                               wready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	// AXI4-Lite write response
	output logic                               bvalid,
	input  wire logic                          bready,
	output logic [1:0]                         bresp,
	// AXI4-Lite read
	input  wire logic                          arvalid,
	output logic                               arready,
	input  wire logic [7:0]                    araddr,
	output logic                               rvalid,
	input  wire logic                          rready,
	output logic [31:0]                        rdata,
	output logic [1:0]                         rresp,
	// Counter clock sources
	input  wire logic                          fixed_clk_tick,
	input  wire logic                          ext_clk,
	// Channel pins
	output logic [tcpc_pkg::NUM_CH-1:0]        ch_pin_out,
	output logic [tcpc_pkg::NUM_CH-1:0]        ch_pin_oe,
	// Interrupts
	output logic                               overflow_irq,
	output logic [tcpc_pkg::NUM_CH-1:0]        channel_irq
);
	tcpc_pkg::tcpc_state_t              s;
	tcpc_pkg::tcpc_state_t              next_s;
	logic                               tick;
	logic                               ovf;
	logic [15:0]                        nc;
	logic [15:0]                        term;
	logic                               wr_go;
	logic                               wr_main;
	logic [tcpc_pkg::NUM_CH-1:0]        wr_cc;
	logic [tcpc_pkg::NUM_CH-1:0]        ch_match;
	logic [tcpc_pkg::NUM_CH-1:0]        ch_load;

	always_comb begin
		logic        src;
		logic        wr_hit;
		logic        rd_hit;
		logic [31:0] rd_val;
		logic [6:0]  pmask;
		logic [7:0]  cbase;
		logic [7:0]  d;
		logic [15:0] v;
		logic        is_cap;
		logic        is_oc;
		logic        is_ep;
		src = 1'b0;
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		rd_val = 32'h0000_0000;
		pmask = 7'h00;
		cbase = 8'h00;
		d = s.wdata[7:0];
		v = tcpc_pkg::VAL_RESET;
		is_cap = 1'b0;
		is_oc = 1'b0;
		is_ep = 1'b0;
		next_s = s;
		tick = 1'b0;
		ovf = 1'b0;
		nc = s.cnt;
		wr_cc = '0;
		ch_match = '0;
		ch_load = '0;

		// Counter clock source and prescaler
		next_s.ext_q = ext_clk;
		unique case (s.clks)
			tcpc_pkg::CLK_OFF:   src = 1'b0;
			tcpc_pkg::CLK_BUS:   src = 1'b1;
			tcpc_pkg::CLK_FIXED: src = fixed_clk_tick;
			tcpc_pkg::CLK_EXT:   src = ext_clk && !s.ext_q;
		endcase
		pmask = 7'((8'h01 << s.ps) - 8'h01);
		if (src) begin
			if (s.pre == pmask) begin
				next_s.pre = 7'h00;
				tick = 1'b1;
			end else begin
				next_s.pre = s.pre + 7'h01;
			end
		end

		// Counter step
		term = (s.modv == tcpc_pkg::CNT_ZERO) ? tcpc_pkg::FREE_TERM : s.modv;
		if (tick) begin
			if (!s.center) begin
				next_s.down = 1'b0;
				if (s.cnt == term) begin
					nc = tcpc_pkg::CNT_ZERO;
					ovf = 1'b1;
				end else begin
					nc = s.cnt + tcpc_pkg::CNT_ONE;
				end
			end else if (!s.down) begin
				if (s.cnt == term) begin
					nc = s.cnt - tcpc_pkg::CNT_ONE;
					next_s.down = 1'b1;
					ovf = 1'b1;
				end else begin
					nc = s.cnt + tcpc_pkg::CNT_ONE;
				end
			end else begin
				if (s.cnt == tcpc_pkg::CNT_ZERO) begin
					nc = s.cnt + tcpc_pkg::CNT_ONE;
					next_s.down = 1'b0;
				end else begin
					nc = s.cnt - tcpc_pkg::CNT_ONE;
				end
			end
			next_s.cnt = nc;
		end

		// Write address and data channels
		if (awvalid && s.awready) begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = {awaddr[7:2], 2'b00};
		end
		if (wvalid && s.wready) begin
			next_s.w_held = 1'b1;
			next_s.wdata = wdata;
			next_s.wstrb = wstrb;
		end
		wr_go = s.aw_held && s.w_held && !s.bvalid;
		wr_main = wr_go && s.wstrb[0] && (s.aw_addr == tcpc_pkg::OFS_MAIN);
		if (wr_go) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			unique case (s.aw_addr)
				tcpc_pkg::OFS_MAIN: begin
					wr_hit = 1'b1;
					if (s.wstrb[0]) begin
						next_s.overflow_irq_enable = d[tcpc_pkg::MSC_IE];
						next_s.center = d[tcpc_pkg::MSC_CENTER];
						next_s.clks = tcpc_pkg::tcpc_clk_t'(d[tcpc_pkg::MSC_CLK_LO +: 2]);
						next_s.ps = d[tcpc_pkg::MSC_PS_LO +: 3];
						if (!d[tcpc_pkg::MSC_FLAG] && s.overflow_arm) begin
							next_s.overflow_flag = 1'b0;
						end
						next_s.overflow_arm = 1'b0;
						next_s.mgot_hi = 1'b0;
						next_s.mgot_lo = 1'b0;
					end
				end
				tcpc_pkg::OFS_COUNT: begin
					wr_hit = 1'b1;
					next_s.cnt = tcpc_pkg::CNT_ZERO;
					next_s.pre = 7'h00;
					next_s.down = 1'b0;
				end
				tcpc_pkg::OFS_MOD_HI: begin
					wr_hit = 1'b1;
					if (s.wstrb[0]) begin
						next_s.mbuf_hi = d;
						next_s.mgot_hi = 1'b1;
					end
				end
				tcpc_pkg::OFS_MOD_LO: begin
					wr_hit = 1'b1;
					if (s.wstrb[0]) begin
						next_s.mbuf_lo = d;
						next_s.mgot_lo = 1'b1;
					end
				end
				default: begin
				end
			endcase
			for (int i = 0; i < tcpc_pkg::NUM_CH; i++) begin
				cbase = tcpc_pkg::OFS_CH_BASE + 8'(i) * tcpc_pkg::OFS_CH_STRIDE;
				if (s.aw_addr == cbase + tcpc_pkg::OFS_CH_CTRL) begin
					wr_hit = 1'b1;
					if (s.wstrb[0]) begin
						wr_cc[i] = 1'b1;
						next_s.ch[i].ie = d[tcpc_pkg::CSC_IE];
						next_s.ch[i].msb = d[tcpc_pkg::CSC_MSB];
						next_s.ch[i].msa = d[tcpc_pkg::CSC_MSA];
						next_s.ch[i].elsb = d[tcpc_pkg::CSC_ELSB];
						next_s.ch[i].elsa = d[tcpc_pkg::CSC_ELSA];
						if (!d[tcpc_pkg::CSC_FLAG] && s.ch[i].arm) begin
							next_s.ch[i].flag = 1'b0;
						end
						next_s.ch[i].arm = 1'b0;
						next_s.ch[i].got_hi = 1'b0;
						next_s.ch[i].got_lo = 1'b0;
						next_s.ch[i].pend = 1'b0;
					end
				end
				if (s.aw_addr == cbase + tcpc_pkg::OFS_CH_VAL_HI) begin
					wr_hit = 1'b1;
					if (s.wstrb[0]) begin
						next_s.ch[i].buf_hi = d;
						next_s.ch[i].got_hi = 1'b1;
					end
				end
				if (s.aw_addr == cbase + tcpc_pkg::OFS_CH_VAL_LO) begin
					wr_hit = 1'b1;
					if (s.wstrb[0]) begin
						next_s.ch[i].buf_lo = d;
						next_s.ch[i].got_lo = 1'b1;
					end
				end
				if (next_s.ch[i].got_hi && next_s.ch[i].got_lo) begin
					next_s.ch[i].got_hi = 1'b0;
					next_s.ch[i].got_lo = 1'b0;
					next_s.ch[i].pend = 1'b1;
				end
			end
			next_s.bresp = wr_hit ? tcpc_pkg::RESP_OKAY : tcpc_pkg::RESP_SLVERR;
		end else if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		if (next_s.mgot_hi && next_s.mgot_lo) begin
			next_s.modv = {next_s.mbuf_hi, next_s.mbuf_lo};
			next_s.mgot_hi = 1'b0;
			next_s.mgot_lo = 1'b0;
		end

		// Read channel
		if (arvalid && s.arready) begin
			if ({araddr[7:2], 2'b00} == tcpc_pkg::OFS_MAIN) begin
				rd_hit = 1'b1;
				rd_val[7:0] = {s.overflow_flag, s.overflow_irq_enable, s.center, s.clks, s.ps};
				if (s.overflow_flag) begin
					next_s.overflow_arm = 1'b1;
				end
			end
			if ({araddr[7:2], 2'b00} == tcpc_pkg::OFS_COUNT) begin
				rd_hit = 1'b1;
				rd_val[15:0] = s.cnt;
			end
			if ({araddr[7:2], 2'b00} == tcpc_pkg::OFS_MOD_HI) begin
				rd_hit = 1'b1;
				rd_val[7:0] = s.modv[15:8];
			end
			if ({araddr[7:2], 2'b00} == tcpc_pkg::OFS_MOD_LO) begin
				rd_hit = 1'b1;
				rd_val[7:0] = s.modv[7:0];
			end
			for (int i = 0; i < tcpc_pkg::NUM_CH; i++) begin
				cbase = tcpc_pkg::OFS_CH_BASE + 8'(i) * tcpc_pkg::OFS_CH_STRIDE;
				if ({araddr[7:2], 2'b00} == cbase + tcpc_pkg::OFS_CH_CTRL) begin
					rd_hit = 1'b1;
					rd_val[7:0] = {s.ch[i].flag, s.ch[i].ie, s.ch[i].msb, s.ch[i].msa,
						s.ch[i].elsb, s.ch[i].elsa, 2'b00};
					if (s.ch[i].flag) begin
						next_s.ch[i].arm = 1'b1;
					end
				end
				if ({araddr[7:2], 2'b00} == cbase + tcpc_pkg::OFS_CH_VAL_HI) begin
					rd_hit = 1'b1;
					rd_val[7:0] = s.ch[i].value[15:8];
				end
				if ({araddr[7:2], 2'b00} == cbase + tcpc_pkg::OFS_CH_VAL_LO) begin
					rd_hit = 1'b1;
					rd_val[7:0] = s.ch[i].value[7:0];
				end
			end
			next_s.rvalid = 1'b1;
			next_s.rdata = rd_val;
			next_s.rresp = rd_hit ? tcpc_pkg::RESP_OKAY : tcpc_pkg::RESP_SLVERR;
		end else if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		next_s.awready = !next_s.aw_held;
		next_s.wready = !next_s.w_held;
		next_s.arready = !next_s.rvalid;

		// Overflow flag, set wins over clear
		if (ovf) begin
			next_s.overflow_flag = 1'b1;
			next_s.overflow_arm = 1'b0;
		end
		next_s.ovf_irq = next_s.overflow_flag && next_s.overflow_irq_enable;

		// Channel outputs, events and value transfer
		for (int i = 0; i < tcpc_pkg::NUM_CH; i++) begin
			v = s.ch[i].value;
			is_cap = !s.center && !s.ch[i].msb && !s.ch[i].msa;
			is_oc = !s.center && !s.ch[i].msb && s.ch[i].msa;
			is_ep = !s.center && s.ch[i].msb;
			next_s.ch[i].oe = (s.ch[i].elsb || s.ch[i].elsa) && !is_cap;
			ch_match[i] = tick && (nc == v) && !is_cap &&
				!(s.center && (v == tcpc_pkg::CNT_ZERO || v[15]));
			if (s.center) begin
				if (v == tcpc_pkg::CNT_ZERO || v[15]) begin
					next_s.ch[i].pin = s.ch[i].elsa;
				end else if (v > term) begin
					next_s.ch[i].pin = !s.ch[i].elsa;
				end else if (ch_match[i]) begin
					next_s.ch[i].pin = next_s.down ? !s.ch[i].elsa : s.ch[i].elsa;
				end
			end else if (is_ep) begin
				if (ch_match[i]) begin
					next_s.ch[i].pin = s.ch[i].elsa;
				end else if (ovf) begin
					next_s.ch[i].pin = !s.ch[i].elsa;
				end
			end else if (is_oc && ch_match[i]) begin
				unique case ({s.ch[i].elsb, s.ch[i].elsa})
					2'b00: next_s.ch[i].pin = s.ch[i].pin;
					2'b01: next_s.ch[i].pin = !s.ch[i].pin;
					2'b10: next_s.ch[i].pin = 1'b0;
					2'b11: next_s.ch[i].pin = 1'b1;
				endcase
			end
			if (ch_match[i]) begin
				next_s.ch[i].flag = 1'b1;
				next_s.ch[i].arm = 1'b0;
			end
			next_s.ch[i].irq = next_s.ch[i].flag && next_s.ch[i].ie;
			ch_load[i] = next_s.ch[i].pend && ((s.clks == tcpc_pkg::CLK_OFF) ||
				(tick && !s.center && !is_ep) ||
				(tick && (s.center || is_ep) && !s.down &&
				s.cnt == term - tcpc_pkg::CNT_ONE));
			if (ch_load[i]) begin
				next_s.ch[i].value = {next_s.ch[i].buf_hi, next_s.ch[i].buf_lo};
				next_s.ch[i].pend = 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from state
	assign awready      = s.awready;
	assign wready       = s.wready;
	assign bvalid       = s.bvalid;
	assign bresp        = s.bresp;
	assign arready      = s.arready;
	assign rvalid       = s.rvalid;
	assign rdata        = s.rdata;
	assign rresp        = s.rresp;
	assign overflow_irq = s.ovf_irq;
	for (genvar g = 0; g < tcpc_pkg::NUM_CH; g++) begin : g_out
		assign ch_pin_out[g]  = s.ch[g].pin;
		assign ch_pin_oe[g]   = s.ch[g].oe;
		assign channel_irq[g] = s.ch[g].irq;
	end

	// Checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_oc_toggle_pin: assert property (ch_match[0] && !s.center && !s.ch[0].msb && s.ch[0].msa &&
		!s.ch[0].elsb && s.ch[0].elsa |=> ch_pin_out[0] != $past(ch_pin_out[0]))
		else $error("compare toggle missed");
	a_oc_load_tick: assert property (!s.center && !s.ch[0].msb && s.ch[0].msa &&
		s.clks != tcpc_pkg::CLK_OFF && $past(s.clks) != tcpc_pkg::CLK_OFF &&
		s.ch[0].value != $past(s.ch[0].value) |-> $past(tick))
		else $error("compare value loaded off tick");
	a_match_sets_flag: assert property (ch_match[0] |=> s.ch[0].flag ##0
		(channel_irq[0] == s.ch[0].ie))
		else $error("channel flag not set");
	a_edge_wrap_zero: assert property (tick && !s.center && s.cnt == term |=>
		s.cnt == tcpc_pkg::CNT_ZERO && s.overflow_flag)
		else $error("up counter did not wrap");
	a_epwm_match_level: assert property (ch_match[0] && !s.center && s.ch[0].msb |=>
		ch_pin_out[0] == $past(s.ch[0].elsa))
		else $error("edge pwm match level wrong");
	a_pwm_load_point: assert property (s.ch[0].msb && !s.center &&
		s.clks != tcpc_pkg::CLK_OFF && $past(s.clks) != tcpc_pkg::CLK_OFF &&
		s.ch[0].value != $past(s.ch[0].value) |->
		$past(s.cnt) == $past(term) - tcpc_pkg::CNT_ONE)
		else $error("pwm value loaded at wrong count");
	a_center_zero_duty: assert property ((s.center && s.ch[0].value == tcpc_pkg::CNT_ZERO &&
		s.ch[0].elsa == $past(s.ch[0].elsa))[*2] |-> ch_pin_out[0] == s.ch[0].elsa)
		else $error("center zero duty not held");
	a_msc_drop_mod: assert property (wr_main |=> !s.mgot_hi && !s.mgot_lo)
		else $error("modulus bytes not dropped");
	a_csc_drop_val: assert property (wr_cc[0] |=> !s.ch[0].got_hi && !s.ch[0].got_lo &&
		!s.ch[0].pend)
		else $error("channel value bytes not dropped");
	a_center_turn: assert property (tick && s.center && !s.down && s.cnt == term |=>
		s.down && s.overflow_flag && s.cnt == $past(term) - tcpc_pkg::CNT_ONE)
		else $error("center turn or overflow flag wrong");
	a_set_beats_clear: assert property (ovf |=> s.overflow_flag ##1
		(overflow_irq == s.overflow_irq_enable))
		else $error("overflow event lost");
	a_irq_static: assert property (overflow_irq ==
		(s.overflow_flag && s.overflow_irq_enable))
		else $error("overflow irq not static");

	c_epwm_match: cover property (ch_match[0] && s.ch[0].msb && !s.center);
	c_center_turn: cover property (tick && s.center && !s.down && s.cnt == term);
	c_ovf_cleared: cover property (s.overflow_flag ##1 !s.overflow_flag);
	c_oc_load: cover property (ch_load[0] && s.clks != tcpc_pkg::CLK_OFF);
endmodule

// file: hw/tcpc_pkg.sv
// Purpose: Constants and state types for the timer compare and PWM block
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word, all byte wide except the 16-bit count
// Notes:   Byte registers sit in bits 7:0, upper bits read as zero
package tcpc_pkg;
	localparam int          NUM_CH        = 2;
	// Register byte addresses
	localparam logic [7:0]  OFS_MAIN      = 8'h00;
	localparam logic [7:0]  OFS_COUNT     = 8'h04;
	localparam logic [7:0]  OFS_MOD_HI    = 8'h08;
	localparam logic [7:0]  OFS_MOD_LO    = 8'h0C;
	localparam logic [7:0]  OFS_CH_BASE   = 8'h10;
	localparam logic [7:0]  OFS_CH_STRIDE = 8'h10;
	localparam logic [7:0]  OFS_CH_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_CH_VAL_HI = 8'h04;
	localparam logic [7:0]  OFS_CH_VAL_LO = 8'h08;
	// Main status/control fields
	localparam int          MSC_FLAG      = 7;
	localparam int          MSC_IE        = 6;
	localparam int          MSC_CENTER    = 5;
	localparam int          MSC_CLK_LO    = 3;
	localparam int          MSC_PS_LO     = 0;
	// Channel status/control fields
	localparam int          CSC_FLAG      = 7;
	localparam int          CSC_IE        = 6;
	localparam int          CSC_MSB       = 5;
	localparam int          CSC_MSA       = 4;
	localparam int          CSC_ELSB      = 3;
	localparam int          CSC_ELSA      = 2;
	// Reset values, counter constants and bus response codes
	localparam logic [15:0] MOD_RESET     = 16'h0000;
	localparam logic [15:0] VAL_RESET     = 16'h0000;
	localparam logic [15:0] CNT_ZERO      = 16'h0000;
	localparam logic [15:0] CNT_ONE       = 16'h0001;
	localparam logic [15:0] FREE_TERM     = 16'hFFFF;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [1:0] {
		CLK_OFF   = 2'h0,
		CLK_BUS   = 2'h1,
		CLK_FIXED = 2'h2,
		CLK_EXT   = 2'h3
	} tcpc_clk_t;

	typedef struct packed {
		logic        flag;
		logic        arm;
		logic        ie;
		logic        msb;
		logic        msa;
		logic        elsb;
		logic        elsa;
		logic [15:0] value;
		logic [7:0]  buf_hi;
		logic [7:0]  buf_lo;
		logic        got_hi;
		logic        got_lo;
		logic        pend;
		logic        pin;
		logic        oe;
		logic        irq;
	} tcpc_chan_t;

	typedef struct packed {
		logic                        awready;
		logic                        wready;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        aw_held;
		logic [7:0]                  aw_addr;
		logic                        w_held;
		logic [31:0]                 wdata;
		logic [3:0]                  wstrb;
		logic                        arready;
		logic                        rvalid;
		logic [31:0]                 rdata;
		logic [1:0]                  rresp;
		logic                        overflow_flag;
		logic                        overflow_arm;
		logic                        overflow_irq_enable;
		logic                        center;
		tcpc_clk_t                   clks;
		logic [2:0]                  ps;
		logic [6:0]                  pre;
		logic [15:0]                 cnt;
		logic                        down;
		logic [15:0]                 modv;
		logic [7:0]                  mbuf_hi;
		logic [7:0]                  mbuf_lo;
		logic                        mgot_hi;
		logic                        mgot_lo;
		logic                        ext_q;
		logic                        ovf_irq;
		tcpc_chan_t [NUM_CH-1:0]     ch;
	} tcpc_state_t;
endpackage

// file: dv/tcpc_load.sv
// Purpose: External load on one channel pin, with a pull-down
// Assumes: Pin is released while its output enable is low
// Notes:   Counts the cycles seen at high level since the last clear
module tcpc_load (
	// Clock and control
	input  wire logic        aclk,
	input  wire logic        clr,
	// Pin from the block
	input  wire logic        pin_out,
	input  wire logic        pin_oe,
	// Observed level and high count
	output logic             level,
	output logic [15:0]      high_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released pin falls to the pull-down
	assign level = pin_oe ? pin_out : 1'b0;
	always_ff @(posedge aclk) begin
		if (clr)
			high_cnt <= 16'h0000;
		else if (level === 1'b1)
			high_cnt <= high_cnt + 16'h0001;
	end
endmodule

// file: dv/tb.sv
// Purpose: Self-checking bench for the compare and PWM block
// Assumes: Bus clock 100 MHz, reset held two cycles
// Notes:   Channel 0 drives the load model
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] A_MAIN = tcpc_pkg::OFS_MAIN;
	localparam logic [7:0] A_CNT  = tcpc_pkg::OFS_COUNT;
	localparam logic [7:0] A_MHI  = tcpc_pkg::OFS_MOD_HI;
	localparam logic [7:0] A_MLO  = tcpc_pkg::OFS_MOD_LO;
	localparam logic [7:0] A_CSC  = tcpc_pkg::OFS_CH_BASE + tcpc_pkg::OFS_CH_CTRL;
	localparam logic [7:0] A_VHI  = tcpc_pkg::OFS_CH_BASE + tcpc_pkg::OFS_CH_VAL_HI;
	localparam logic [7:0] A_VLO  = tcpc_pkg::OFS_CH_BASE + tcpc_pkg::OFS_CH_VAL_LO;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        fixed_clk_tick, ext_clk, clr, awready, wready, bvalid;
	logic        arready, rvalid, overflow_irq, level;
	logic [1:0]  bresp, rresp, rr_q, br_q, ch_pin_out, ch_pin_oe, channel_irq, phase;
	logic [3:0]  wstrb;
	logic [7:0]  awaddr, araddr;
	logic [15:0] high_cnt;
	logic [31:0] wdata, rdata, rd_q;
	int          cyc, checked, miscompares;

	tcpc_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .fixed_clk_tick(fixed_clk_tick), .ext_clk(ext_clk),
		.ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe), .overflow_irq(overflow_irq),
		.channel_irq(channel_irq));
	tcpc_load load (.aclk(aclk), .clr(clr), .pin_out(ch_pin_out[0]),
		.pin_oe(ch_pin_oe[0]), .level(level), .high_cnt(high_cnt));

	always #5 aclk = ~aclk;
	// Fixed tick and external source, both a quarter of the bus rate
	always @(posedge aclk) begin
		phase <= phase + 2'h1;
		fixed_clk_tick <= (phase == 2'h3);
		ext_clk <= phase[1];
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			miscompares++;
			report_and_stop;
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		br_q = bresp;
	endtask

	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk);
		while (rvalid !== 1'b1);
		rd_q = rdata;
		rr_q = rresp;
	endtask

	// New duty value, settle, then count high cycles over the next n cycles
	task automatic pwm_val(input logic [15:0] v, input int n, input logic [31:0] e);
		wr(A_VHI, v[15:8]);
		wr(A_VLO, v[7:0]);
		repeat (40) @(posedge aclk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		repeat (n + 1) @(posedge aclk);
		chk("high_count", 32'(high_cnt), e);
	endtask

	task automatic t_reset;
		rd(A_MAIN);
		chk("main_ctrl", rd_q, 32'h0000_0000);
		chk("read_okay", 32'(rr_q), 32'(tcpc_pkg::RESP_OKAY));
		chk("pins_irqs", 32'({ch_pin_out, channel_irq, overflow_irq}), 32'h0000_0000);
		rd(A_CSC);
		chk("chan_ctrl", rd_q, 32'h0000_0000);
		chk("pin_oe", 32'(ch_pin_oe), 32'h0000_0000);
		rd(8'h3C);
		chk("unmapped", 32'(rr_q), 32'(tcpc_pkg::RESP_SLVERR));
		wr(8'h3C, 8'h00);
		chk("unmapped_wr", 32'(br_q), 32'(tcpc_pkg::RESP_SLVERR));
		$display("t_reset done");
	endtask

	task automatic t_clksel;
		int          div [4] = '{0, 1, 4, 4};
		logic [31:0] e;
		for (int c = 0; c < 4; c++) begin
			wr(A_MAIN, 8'(c << 3));
			wr(A_CNT, 8'h00);
			repeat (64) @(posedge aclk);
			wr(A_MAIN, 8'h00);
			rd(A_CNT);
			e = (div[c] == 0) ? 32'h0000_0000 : 32'(64 / div[c]);
			chk("tick_rate", 32'((rd_q - e) <= ((div[c] == 0) ? 0 : 6)), 32'h0000_0001);
		end
		$display("t_clksel done");
	endtask

	task automatic t_compare;
		logic prev;
		wr(A_CSC, 8'h1C);
		chk("write_okay", 32'(br_q), 32'(tcpc_pkg::RESP_OKAY));
		wr(A_VHI, 8'h01);
		rd(A_VHI);
		chk("val_buffered", rd_q, 32'h0000_0000);
		wr(A_CSC, 8'h1C);
		wr(A_VLO, 8'h20);
		rd(A_VLO);
		chk("val_dropped", rd_q, 32'h0000_0000);
		wr(A_VHI, 8'h00);
		rd(A_VLO);
		chk("val_direct", rd_q, 32'h0000_0020);
		for (int c = 1; c < 4; c++) begin
			wr(A_CSC, 8'(8'h50 | (c << 2)));
			wr(A_CNT, 8'h00);
			prev = ch_pin_out[0];
			wr(A_MAIN, 8'h08);
			for (int i = 0; i < 100 && channel_irq[0] !== 1'b1; i++) @(posedge aclk);
			chk("chan_irq", 32'(channel_irq[0]), 32'h0000_0001);
			chk("oc_pin", 32'(ch_pin_out[0]), 32'((c == 1) ? !prev : (c == 3)));
			wr(A_MAIN, 8'h00);
			rd(A_CSC);
			chk("chan_flag", 32'(rd_q[7]), 32'h0000_0001);
			wr(A_CSC, 8'(8'h50 | (c << 2)));
			repeat (2) @(posedge aclk);
			chk("flag_clear", 32'(channel_irq[0]), 32'h0000_0000);
		end
		// Slow tick: new compare value waits for the next counter change
		wr(A_CNT, 8'h00);
		wr(A_MAIN, 8'h0F);
		wr(A_VHI, 8'h00);
		wr(A_VLO, 8'h40);
		rd(A_VLO);
		chk("val_wait_tick", rd_q, 32'h0000_0020);
		repeat (130) @(posedge aclk);
		rd(A_VLO);
		chk("val_on_tick", rd_q, 32'h0000_0040);
		wr(A_MAIN, 8'h00);
		$display("t_compare done");
	endtask

	task automatic t_edge;
		wr(A_MHI, 8'h00);
		wr(A_MLO, 8'h09);
		wr(A_CSC, 8'h28);
		wr(A_CNT, 8'h00);
		wr(A_MAIN, 8'h08);
		pwm_val(16'h0003, 40, 32'h0000_000C);
		pwm_val(16'h0000, 40, 32'h0000_0000);
		pwm_val(16'h000C, 40, 32'h0000_0028);
		wr(A_CSC, 8'h2C);
		pwm_val(16'h0003, 40, 32'h0000_001C);
		wr(A_MAIN, 8'h00);
		$display("t_edge done");
	endtask

	task automatic t_center;
		wr(A_MHI, 8'h00);
		wr(A_MLO, 8'h08);
		wr(A_CSC, 8'h08);
		wr(A_CNT, 8'h00);
		wr(A_MAIN, 8'h68);
		pwm_val(16'h0003, 32, 32'h0000_000C);
		pwm_val(16'h0000, 32, 32'h0000_0000);
		pwm_val(16'h8000, 32, 32'h0000_0000);
		pwm_val(16'h0009, 32, 32'h0000_0020);
		wr(A_MLO, 8'h05);
		wr(A_MAIN, 8'h68);
		wr(A_MHI, 8'h00);
		pwm_val(16'h0003, 32, 32'h0000_000C);
		wr(A_CSC, 8'h0C);
		pwm_val(16'h0003, 32, 32'h0000_0014);
		chk("ovf_irq", 32'(overflow_irq), 32'h0000_0001);
		rd(A_MAIN);
		chk("ovf_flag", 32'(rd_q[7]), 32'h0000_0001);
		wr(A_MAIN, 8'h00);
		$display("t_center done");
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		{aclk, aresetn, awvalid, wvalid, arvalid, fixed_clk_tick, ext_clk, clr} = 8'h00;
		{bready, rready, wstrb, phase, cyc, checked, miscompares} = '0;
		bready = 1'b1;
		rready = 1'b1;
		wstrb = 4'hF;
		{awaddr, araddr, wdata} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset;
		t_clksel;
		t_compare;
		t_edge;
		t_center;
		report_and_stop;
	end
endmodule
